// *** core/device_disable_runtime_regs.sv ***
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ddr_params.svh"

// What this block does
// - shadow register at index 21 shows second serial port fifo settings, bits 5:4 zero
// - disable register read-only when lock field is 01 and lock pin is 1
// - disable bits 7:3 at 0 leave activate bits in control; at 1 force off
// - with bit 0 clear, protect comes from the protect pin and the forced bit, the forced bit counting only with ds0 or ds1 high
// - with bit 0 set, media reads as write protected regardless of other sources
// - core protect = ds0 and force, or ds1 and force, or pin, or bit 0
// - disable register bits 2 and 1 always read as zero
// - bit 3 set disables the floppy controller, else activate bit governs
// - bit 4 set disables the midi serial port, else activate bit governs
// - bit 5 set disables the second serial port, else activate bit governs
// - bit 6 set disables the first serial port, else activate bit governs
// - bit 7 set disables the parallel port, else activate bit governs
module device_disable_runtime_regs
   import ddr_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // axi4-lite write address
   input  wire logic [11:0]       awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   // axi4-lite write data
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // axi4-lite write response
   output ddr_pkg::resp_type      bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi4-lite read address
   input  wire logic [11:0]       araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   // axi4-lite read data
   output logic [31:0]            rdata,
   output ddr_pkg::resp_type      rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // second serial port fifo control, same clock
   input  wire logic [7:0]        second_serial_fifo_ctrl,
   // lock source
   input  wire logic              lock_control_pin,
   input  wire logic [1:0]        lock_cfg_field,
   // activate bits of the functions
   input  wire logic              floppy_activate,
   input  wire logic              midi_activate,
   input  wire logic              second_serial_activate,
   input  wire logic              first_serial_activate,
   input  wire logic              parallel_activate,
   // write protect sources
   input  wire logic              write_protect_n,
   input  wire logic              drive_select_zero_n,
   input  wire logic              drive_select_one_n,
   input  wire logic              force_write_protect,
   // effective enables and protect
   output logic                   floppy_enable,
   output logic                   midi_enable,
   output logic                   second_serial_enable,
   output logic                   first_serial_enable,
   output logic                   parallel_enable,
   output logic                   write_protect_to_core
);

   import ddr_pkg::*;

   function automatic sel_type decode_sel(input logic [11:0] addr);
      if (addr[11:2] == `SHADOW_IDX)
         return SEL_SHADOW;
      else if (addr[11:2] == `DISABLE_IDX)
         return SEL_DISABLE;
      else
         return SEL_NONE;
   endfunction

   // pin synchronisers
   logic [1:0] pins_s;
   logic       lock_pin_s;
   logic       wp_pin_s;

   pin_sync #(.WIDTH(2)) u_sync (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .pin_in       ({write_protect_n, lock_control_pin}),
      .pin_sync_out (pins_s)
   );

   assign lock_pin_s = pins_s[0];
   assign wp_pin_s   = pins_s[1];

   // state
   ch_state_type wr_state_r, wr_state_nxt;
   ch_state_type rd_state_r, rd_state_nxt;
   logic         aw_got_r, aw_got_nxt;
   logic         w_got_r, w_got_nxt;
   logic [11:0]  waddr_r, waddr_nxt;
   logic [7:0]   wbyte_r, wbyte_nxt;
   logic         wlane_r, wlane_nxt;
   logic         awready_r, awready_nxt;
   logic         wready_r, wready_nxt;
   resp_type     bresp_r, bresp_nxt;
   logic         bvalid_r, bvalid_nxt;
   logic         arready_r, arready_nxt;
   logic [31:0]  rdata_r, rdata_nxt;
   resp_type     rresp_r, rresp_nxt;
   logic         rvalid_r, rvalid_nxt;
   logic [7:0]   disable_r, disable_nxt;
   logic [7:0]   shadow_r, shadow_nxt;
   logic [4:0]   enable_r, enable_nxt;
   logic         wp_core_r, wp_core_nxt;
   logic         locked;
   logic         wr_commit;
   logic         wp_merged;
   logic [4:0]   activate_vec;

   assign locked = (lock_cfg_field == `LOCK_CFG_CODE) && lock_pin_s;
   assign activate_vec = {parallel_activate, first_serial_activate, second_serial_activate,
                          midi_activate, floppy_activate};

   // write channel: address and data taken in either order
   always_comb begin
      aw_got_nxt   = aw_got_r | (awvalid & awready_r);
      w_got_nxt    = w_got_r | (wvalid & wready_r);
      waddr_nxt    = (awvalid & awready_r) ? awaddr : waddr_r;
      wbyte_nxt    = (wvalid & wready_r) ? wdata[7:0] : wbyte_r;
      wlane_nxt    = (wvalid & wready_r) ? wstrb[0] : wlane_r;
      wr_state_nxt = wr_state_r;
      bresp_nxt    = bresp_r;
      bvalid_nxt   = bvalid_r;
      wr_commit    = 1'b0;
      unique case (wr_state_r)
         CH_IDLE: begin
            if (aw_got_nxt && w_got_nxt) begin
               wr_commit    = 1'b1;
               aw_got_nxt   = 1'b0;
               w_got_nxt    = 1'b0;
               bvalid_nxt   = 1'b1;
               wr_state_nxt = CH_RESP;
               unique case (decode_sel(waddr_nxt))
                  SEL_DISABLE: bresp_nxt = RESP_OKAY;
                  SEL_SHADOW:  bresp_nxt = RESP_SLVERR;
                  SEL_NONE:    bresp_nxt = RESP_DECERR;
               endcase
            end
         end
         CH_RESP: begin
            if (bready) begin
               bvalid_nxt   = 1'b0;
               wr_state_nxt = CH_IDLE;
            end
         end
      endcase
      awready_nxt = !aw_got_nxt && (wr_state_nxt == CH_IDLE);
      wready_nxt  = !w_got_nxt && (wr_state_nxt == CH_IDLE);
   end

   // disable register: writes only while unlocked
   always_comb begin
      disable_nxt = disable_r;
      if (wr_commit && wlane_nxt && !locked && decode_sel(waddr_nxt) == SEL_DISABLE)
         disable_nxt = wbyte_nxt & `DIS_RW_MASK;
   end

   // read channel
   always_comb begin
      rd_state_nxt = rd_state_r;
      rdata_nxt    = rdata_r;
      rresp_nxt    = rresp_r;
      rvalid_nxt   = rvalid_r;
      unique case (rd_state_r)
         CH_IDLE: begin
            if (arvalid && arready_r) begin
               rvalid_nxt   = 1'b1;
               rd_state_nxt = CH_RESP;
               unique case (decode_sel(araddr))
                  SEL_SHADOW: begin
                     rdata_nxt = {24'h000000, shadow_r};
                     rresp_nxt = RESP_OKAY;
                  end
                  SEL_DISABLE: begin
                     rdata_nxt = {24'h000000, disable_r};
                     rresp_nxt = RESP_OKAY;
                  end
                  SEL_NONE: begin
                     rdata_nxt = 32'h00000000;
                     rresp_nxt = RESP_DECERR;
                  end
               endcase
            end
         end
         CH_RESP: begin
            if (rready) begin
               rvalid_nxt   = 1'b0;
               rd_state_nxt = CH_IDLE;
            end
         end
      endcase
      arready_nxt = (rd_state_nxt == CH_IDLE);
   end

   // function enables and protect
   wp_merge u_wp (
      .drive_select_zero_n (drive_select_zero_n),
      .drive_select_one_n  (drive_select_one_n),
      .force_write_protect (force_write_protect),
      .write_protect_n     (wp_pin_s),
      .override_protect    (disable_r[`DIS_WP_BIT]),
      .protect_out         (wp_merged)
   );

   always_comb begin
      shadow_nxt  = second_serial_fifo_ctrl & `SHADOW_MASK;
      enable_nxt  = activate_vec & ~disable_r[`DIS_FUNC_MSB:`DIS_FUNC_LSB];
      wp_core_nxt = wp_merged;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_state_r <= CH_IDLE;
         rd_state_r <= CH_IDLE;
         aw_got_r   <= 1'b0;
         w_got_r    <= 1'b0;
         waddr_r    <= 12'h000;
         wbyte_r    <= 8'h00;
         wlane_r    <= 1'b0;
         awready_r  <= 1'b0;
         wready_r   <= 1'b0;
         bresp_r    <= RESP_OKAY;
         bvalid_r   <= 1'b0;
         arready_r  <= 1'b0;
         rdata_r    <= 32'h00000000;
         rresp_r    <= RESP_OKAY;
         rvalid_r   <= 1'b0;
         disable_r  <= `DISABLE_RESET;
         shadow_r   <= `SHADOW_RESET;
         enable_r   <= 5'h00;
         wp_core_r  <= 1'b0;
      end else begin
         wr_state_r <= wr_state_nxt;
         rd_state_r <= rd_state_nxt;
         aw_got_r   <= aw_got_nxt;
         w_got_r    <= w_got_nxt;
         waddr_r    <= waddr_nxt;
         wbyte_r    <= wbyte_nxt;
         wlane_r    <= wlane_nxt;
         awready_r  <= awready_nxt;
         wready_r   <= wready_nxt;
         bresp_r    <= bresp_nxt;
         bvalid_r   <= bvalid_nxt;
         arready_r  <= arready_nxt;
         rdata_r    <= rdata_nxt;
         rresp_r    <= rresp_nxt;
         rvalid_r   <= rvalid_nxt;
         disable_r  <= disable_nxt;
         shadow_r   <= shadow_nxt;
         enable_r   <= enable_nxt;
         wp_core_r  <= wp_core_nxt;
      end
   end

   assign awready               = awready_r;
   assign wready                = wready_r;
   assign bresp                 = bresp_r;
   assign bvalid                = bvalid_r;
   assign arready               = arready_r;
   assign rdata                 = rdata_r;
   assign rresp                 = rresp_r;
   assign rvalid                = rvalid_r;
   assign floppy_enable         = enable_r[0];
   assign midi_enable           = enable_r[1];
   assign second_serial_enable  = enable_r[2];
   assign first_serial_enable   = enable_r[3];
   assign parallel_enable       = enable_r[4];
   assign write_protect_to_core = wp_core_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   chk_shadow_read: assert property (
      (arvalid && arready && decode_sel(araddr) == SEL_SHADOW)
      |=> (rdata[7:0] == $past(shadow_r) && rdata[5:4] == 2'b00 && rdata[31:8] == 24'h000000))
      else $error("shadow read data wrong");

   chk_unlocked_write: assert property (
      (wr_commit && wlane_nxt && !locked && decode_sel(waddr_nxt) == SEL_DISABLE)
      |=> disable_r == ($past(wbyte_nxt) & `DIS_RW_MASK))
      else $error("unlocked write not stored");

   chk_locked_hold: assert property (
      locked |=> $stable(disable_r))
      else $error("disable register changed while locked");

   chk_reserved_zero: assert property (
      (arvalid && arready && decode_sel(araddr) == SEL_DISABLE)
      |=> (rdata[2:1] == 2'b00 && rdata[7:0] == $past(disable_r)))
      else $error("disable register read wrong");

   chk_func_override: assert property (
      1'b1 |=> (enable_r & $past(disable_r[7:3])) == 5'h00)
      else $error("disabled function still enabled");

   chk_func_follow: assert property (
      (disable_r[7:3] == 5'h00) |=> enable_r == $past(activate_vec))
      else $error("enable does not follow activate");

   chk_wp_forced: assert property (
      disable_r[0] |=> write_protect_to_core)
      else $error("override protect not seen");

   chk_wp_sources: assert property (
      (!disable_r[0] && !force_write_protect) |=> write_protect_to_core == $past(wp_pin_s))
      else $error("protect not taken from pin");

   chk_read_answer: assert property (
      (arvalid && arready) |=> rvalid)
      else $error("read answer late");

   cov_write_disable: cover property (wr_commit && !locked && decode_sel(waddr_nxt) == SEL_DISABLE);
   cov_locked_write: cover property (wr_commit && locked && decode_sel(waddr_nxt) == SEL_DISABLE);
   cov_read_shadow: cover property (arvalid && arready && decode_sel(araddr) == SEL_SHADOW);
   cov_unmapped: cover property (rvalid && rresp == RESP_DECERR);

endmodule

// *** core/ddr_params.svh ***
`ifndef DDR_PARAMS_SVH
`define DDR_PARAMS_SVH

// register word indices; byte address is four times the index
`define SHADOW_IDX     10'h021
`define DISABLE_IDX    10'h022

// field positions in the function disable register
`define DIS_WP_BIT     0
`define DIS_FUNC_LSB   3
`define DIS_FUNC_MSB   7

// stored bits of the disable register; bits 2:1 always read zero
`define DIS_RW_MASK    8'hf9
`define DISABLE_RESET  8'h00

// shadow bits 5:4 are reserved and read zero
`define SHADOW_MASK    8'hcf
`define SHADOW_RESET   8'h00

// lock configuration code that arms the lock pin
`define LOCK_CFG_CODE  2'b01

`endif

// *** core/ddr_pkg.sv ***
package ddr_pkg;

   typedef enum logic [1:0] {
      RESP_OKAY   = 2'b00,
      RESP_EXOKAY = 2'b01,
      RESP_SLVERR = 2'b10,
      RESP_DECERR = 2'b11
   } resp_type;

   typedef enum logic [1:0] {
      SEL_NONE    = 2'b00,
      SEL_SHADOW  = 2'b01,
      SEL_DISABLE = 2'b11
   } sel_type;

   typedef enum logic {
      CH_IDLE = 1'b0,
      CH_RESP = 1'b1
   } ch_state_type;

endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/1ps

module pin_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // pins and synchronised levels
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync_out
);

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage1_r <= '0;
         stage2_r <= '0;
      end else begin
         stage1_r <= pin_in;
         stage2_r <= stage1_r;
      end
   end

   assign pin_sync_out = stage2_r;

endmodule

// *** core/wp_merge.sv ***
`timescale 1ns/1ps

module wp_merge (
   // drive selects and protect sources
   input  wire logic drive_select_zero_n,
   input  wire logic drive_select_one_n,
   input  wire logic force_write_protect,
   input  wire logic write_protect_n,
   input  wire logic override_protect,
   // merged level toward the floppy core
   output logic      protect_out
);

   // merged protect level, taken term by term
   assign protect_out = (drive_select_zero_n & force_write_protect) |
                        (drive_select_one_n & force_write_protect) |
                        write_protect_n |
                        override_protect;

endmodule

// *** sim/tb_device_disable_runtime_regs.sv ***
`timescale 1ns/1ps
`include "ddr_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end
module tb_device_disable_runtime_regs;
   import ddr_pkg::*;
   localparam logic [11:0] shadow_addr  = {`SHADOW_IDX, 2'b00};
   localparam logic [11:0] disable_addr = {`DISABLE_IDX, 2'b00};
   logic        clk_sys, rst;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   resp_type    bresp, rresp;
   logic [7:0]  fifo_ctrl;
   logic        lock_pin, wp_n, ds0_n, ds1_n, force_wp, wp_core;
   logic [1:0]  lock_cfg;
   logic [4:0]  act;
   wire [4:0]   en;
   int          miscompares, num_checks;

   device_disable_runtime_regs u_dut (
      .clk_sys(clk_sys), .rst(rst),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .second_serial_fifo_ctrl(fifo_ctrl), .lock_control_pin(lock_pin), .lock_cfg_field(lock_cfg),
      .floppy_activate(act[0]), .midi_activate(act[1]), .second_serial_activate(act[2]),
      .first_serial_activate(act[3]), .parallel_activate(act[4]),
      .write_protect_n(wp_n), .drive_select_zero_n(ds0_n), .drive_select_one_n(ds1_n),
      .force_write_protect(force_wp),
      .floppy_enable(en[0]), .midi_enable(en[1]), .second_serial_enable(en[2]),
      .first_serial_enable(en[3]), .parallel_enable(en[4]), .write_protect_to_core(wp_core)
   );

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic no_answer(input int n);
      if (n >= 64) begin
         miscompares++;
         $display("wrong value at %0t: no bus answer", $time);
         tally_and_finish();
      end
   endtask

   // each channel is released at the edge that takes it
   task automatic bus_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                            output resp_type r);
      int n;
      n = 0;
      @(posedge clk_sys);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 64);
      no_answer(n);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic bus_read(input logic [11:0] a, output logic [31:0] d, output resp_type r);
      int n;
      n = 0;
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 64);
      no_answer(n);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic set_dis(input logic [7:0] d);
      resp_type r;
      bus_write(disable_addr, d, 4'hf, r);
      `CHK(r, RESP_OKAY)
   endtask

   task automatic rd_dis(output logic [31:0] d);
      resp_type r;
      bus_read(disable_addr, d, r);
      `CHK(r, RESP_OKAY)
   endtask

   task automatic t_reset();
      logic [31:0] d;
      rd_dis(d);
      `CHK(d, 32'h0)
      `CHK(en, 5'h1f)
      `CHK(wp_core, 1'b0)
   endtask

   task automatic t_shadow();
      logic [31:0] d;
      resp_type    r;
      logic [7:0]  pat [3] = '{8'hff, 8'h5a, 8'ha5};
      for (int i = 0; i < 3; i++) begin
         fifo_ctrl <= pat[i];
         repeat (2) @(posedge clk_sys);
         bus_read(shadow_addr, d, r);
         `CHK(r, RESP_OKAY)
         `CHK(d, {24'h0, pat[i] & 8'hcf})
      end
      bus_write(shadow_addr, 8'h00, 4'hf, r);
      `CHK(r, RESP_SLVERR)
      bus_read(shadow_addr, d, r);
      `CHK(d, 32'h85)
      bus_read(12'h08c, d, r);
      `CHK(r, RESP_DECERR)
      `CHK(d, 32'h0)
      bus_write(12'h08c, 8'hff, 4'hf, r);
      `CHK(r, RESP_DECERR)
   endtask

   task automatic t_disable();
      logic [31:0] d;
      resp_type    r;
      for (int b = 3; b < 8; b++) begin
         set_dis(8'h01 << b);
         rd_dis(d);
         `CHK(d, 32'h1 << b)
         repeat (2) @(posedge clk_sys);
         `CHK(en, ~(5'h01 << (b - 3)))
      end
      set_dis(8'h00);
      act <= 5'h0a;
      repeat (3) @(posedge clk_sys);
      `CHK(en, 5'h0a)
      set_dis(8'hff);
      rd_dis(d);
      `CHK(d, 32'hf9)
      repeat (2) @(posedge clk_sys);
      `CHK(en, 5'h00)
      act <= 5'h1f;
      bus_write(disable_addr, 8'h00, 4'h0, r);
      rd_dis(d);
      `CHK(d, 32'hf9)
      set_dis(8'h00);
   endtask

   // a reset in mid-run must clear the stored disable bits and every output
   task automatic t_midreset();
      logic [31:0] d;
      set_dis(8'h29);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      `CHK(en, 5'h00)
      `CHK({awready, wready, arready, bvalid, rvalid}, 5'h00)
      rst <= 1'b0;
      rd_dis(d);
      `CHK(d, 32'h0)
      `CHK(en, 5'h1f)
      `CHK(wp_core, 1'b0)
   endtask

   task automatic t_protect();
      logic [3:0] v;
      logic       e;
      for (int b = 0; b < 2; b++) begin
         set_dis(8'(b));
         for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            @(posedge clk_sys);
            {ds0_n, ds1_n, force_wp, wp_n} <= v;
            repeat (5) @(posedge clk_sys);
            e = (v[3] & v[1]) | (v[2] & v[1]) | v[0] | b[0];
            `CHK(wp_core, e)
         end
      end
   endtask

   // lock takes hold only for field code 01 with the pin high
   task automatic t_lock();
      logic [31:0] d;
      resp_type    r;
      logic        lk;
      for (int c = 0; c < 4; c++) begin
         for (int p = 0; p < 2; p++) begin
            set_dis(8'h00);
            lk = (c == 1 && p == 1);
            lock_cfg <= 2'(c);
            lock_pin <= p[0];
            repeat (4) @(posedge clk_sys);
            bus_write(disable_addr, 8'h28, 4'hf, r);
            `CHK(r, RESP_OKAY)
            rd_dis(d);
            `CHK(d, lk ? 32'h0 : 32'h28)
            `CHK(en, lk ? 5'h1f : 5'h1a)
            lock_pin <= 1'b0;
            repeat (4) @(posedge clk_sys);
         end
      end
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial begin
      rst = 1'b1;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {fifo_ctrl, lock_pin, lock_cfg} = '0;
      {wp_n, ds0_n, ds1_n, force_wp} = '0;
      act = 5'h1f;
      miscompares = 0;
      num_checks = 0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_shadow();
      t_disable();
      t_midreset();
      t_protect();
      t_lock();
      tally_and_finish();
   end
endmodule
